// >>> design/bmfe_top.v
// Behaviour
// - Start, stop conditions; data changes while clock low.
// - Eight bits then acknowledge on ninth clock.
// - Select byte 000001 then strap bit, rw.
// - Acknowledge register addresses 00h to 49h only.
// - Further write bytes go to next address.
// - Read: address write, repeated start, read select.
// - Master acks continue readback; nack, stop ends.
// - Write-only ranges give no meaningful readback.
// - Oversample frame gate, strobe data at rate.
// - One sample per bit, first at half.
// - Encoder over GF(256), generator roots a^0..a^2t-1.
// - Encoding enabled by control bit or pin.
// - Codeword is K plus 2t; t=0 bypasses.
// - Serial input ignored during check-byte slots.
// - Control bit selects encoder/randomizer order.
// - Output released six symbol periods after input.
`timescale 1ns/1ps
`include "bmfe_regs.vh"
module bmfe_top #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	input  wire       i_clk,
	input  wire       i_arst_n,
	input  wire       i_scl,
	input  wire       i_sda,
	output reg        o_sda_out,
	output reg        o_sda_oe,
	input  wire       i_addr_sel,
	input  wire       i_burst_frame_gate,
	input  wire       i_serial_data,
	input  wire       i_fec_enable,
	output reg        o_path_order_swap,
	output reg        o_fec_active,
	output reg        o_overrun,
	output reg        o_byte_valid,
	output reg  [7:0] o_byte,
	input  wire       i_byte_ready
);
	// ---------------------------------------------------------------
	// Shared functions
	// ---------------------------------------------------------------
	function [7:0] gmul;
		input [7:0] a;
		input [7:0] b;
		reg   [7:0] r;
		reg   [7:0] x;
		integer     k;
		begin
			r = 8'h00;
			x = a;
			for (k = 0; k < 8; k = k + 1) begin
				if (b[k])
					r = r ^ x;
				x = x[7] ? ({x[6:0], 1'b0} ^ `BMFE_GF_POLY) :
					{x[6:0], 1'b0};
			end
			gmul = r;
		end
	endfunction

	function readable;
		input [6:0] a;
		begin
			readable = !((a >= `BMFE_WO_A_LO && a <= `BMFE_WO_A_HI) ||
				(a >= `BMFE_WO_B_LO && a <= `BMFE_WO_B_HI));
		end
	endfunction

	// ---------------------------------------------------------------
	// Reset release and input synchronisers
	// ---------------------------------------------------------------
	reg [1:0] rst_sync;
	wire      rst_n;
	reg [5:0] in_q1;
	reg [5:0] in_q2;
	reg       scl_p;
	reg       sda_p;
	reg       gate_p;
	wire      scl_s;
	wire      sda_s;
	wire      gate_s;
	wire      data_s;
	wire      fecpin_s;
	wire      addrsel_s;

	// Reset asserts at once and releases after two clock edges.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// The six bus, burst, FEC and strap pins pass two flops; only the second copy is used.
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_q1  <= 6'h1B;
			in_q2  <= 6'h1B;
			scl_p  <= 1'b1;
			sda_p  <= 1'b1;
			gate_p <= 1'b0;
		end else begin
			in_q1  <= {i_addr_sel, i_scl, i_sda,
				i_burst_frame_gate, i_serial_data, i_fec_enable};
			in_q2  <= in_q1;
			scl_p  <= scl_s;
			sda_p  <= sda_s;
			gate_p <= gate_s;
		end
	end
	assign scl_s    = in_q2[4];
	assign sda_s    = in_q2[3];
	assign gate_s   = in_q2[2];
	assign data_s   = in_q2[1];
	assign fecpin_s = in_q2[0];
	assign addrsel_s = in_q2[5];

	// ---------------------------------------------------------------
	// Two-wire control slave
	// ---------------------------------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_DEV  = 3'h1;
	localparam ST_REG  = 3'h2;
	localparam ST_WR   = 3'h3;
	localparam ST_RD   = 3'h4;

	reg [7:0] regs [0:`BMFE_REG_COUNT-1];
	reg [2:0] state;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg [7:0] tx;
	reg [6:0] ptr;
	reg       seq;
	reg       rd_first;
	reg       rd_end;
	reg       mack;
	wire      scl_rise;
	wire      scl_fall;
	wire      start_c;
	wire      stop_c;
	wire      dev_ok;
	wire [7:0] rd_val;
	integer   ri;

	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_c  = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c   = scl_s & scl_p & ~sda_p & sda_s;
	assign dev_ok   = (shreg[7:2] == `BMFE_DEV_FIXED) &&
		(shreg[`BMFE_DEV_SEL_BIT] == addrsel_s);
	// Write-only locations and the end of a sequential run read zero.
	assign rd_val   = (readable(ptr) && !rd_end) ?
		regs[ptr] : `BMFE_REG_RESET;

	// The line is only ever pulled low, so the output level is zero
	// and the enable carries the data. It changes on falling clock.
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= ST_IDLE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			tx       <= 8'h00;
			ptr      <= 7'h00;
			seq      <= 1'b0;
			rd_first <= 1'b0;
			rd_end   <= 1'b0;
			mack     <= 1'b0;
			o_sda_oe <= 1'b0;
			for (ri = 0; ri < `BMFE_REG_COUNT; ri = ri + 1)
				regs[ri] <= `BMFE_REG_RESET;
		end else if (stop_c) begin
			state    <= ST_IDLE;
			o_sda_oe <= 1'b0;
		end else if (start_c) begin
			state    <= ST_DEV;
			// The start's own falling clock wraps this to zero, so it
			// is not mistaken for the end of the first data bit.
			bitcnt   <= 4'hF;
			o_sda_oe <= 1'b0;
		end else if (state != ST_IDLE) begin
			if (scl_rise) begin
				if (bitcnt < 4'h8)
					shreg <= {shreg[6:0], sda_s};
				else if (state == ST_RD)
					mack <= ~sda_s;
			end else if (scl_fall) begin
				if (bitcnt == 4'h7) begin
					bitcnt <= 4'h8;
					o_sda_oe <= 1'b0;
					case (state)
					ST_DEV: begin
						if (dev_ok) begin
							o_sda_oe <= 1'b1;
							rd_first <= 1'b1;
							rd_end   <= 1'b0;
							state <= shreg[`BMFE_DEV_RW_BIT] ?
								ST_RD : ST_REG;
						end else begin
							state <= ST_IDLE;
						end
					end
					ST_REG: begin
						if (shreg[7] == 1'b0 &&
							shreg[6:0] <= `BMFE_REG_LAST) begin
							o_sda_oe <= 1'b1;
							ptr   <= shreg[6:0];
							seq   <= 1'b0;
							state <= ST_WR;
						end else begin
							state <= ST_IDLE;
						end
					end
					ST_WR: begin
						if (seq && ptr >= `BMFE_REG_LAST) begin
							state <= ST_IDLE;
						end else begin
							o_sda_oe  <= 1'b1;
							regs[ptr] <= shreg;
							seq <= 1'b1;
							if (ptr < `BMFE_REG_LAST)
								ptr <= ptr + 7'h01;
						end
					end
					default: begin
						o_sda_oe <= 1'b0;
					end
					endcase
				end else if (bitcnt == 4'h8) begin
					bitcnt   <= 4'h0;
					o_sda_oe <= 1'b0;
					if (state == ST_RD) begin
						if (rd_first || mack) begin
							rd_first <= 1'b0;
							tx       <= rd_val;
							o_sda_oe <= ~rd_val[7];
							if (ptr >= `BMFE_REG_SEQ_LAST)
								rd_end <= 1'b1;
							else
								ptr <= ptr + 7'h01;
						end else begin
							state <= ST_IDLE;
						end
					end
				end else begin
					bitcnt <= bitcnt + 4'h1;
					if (state == ST_RD) begin
						tx       <= {tx[6:0], 1'b0};
						o_sda_oe <= ~tx[6];
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Configuration decode
	// ---------------------------------------------------------------
	wire [7:0] msg_len;
	wire [3:0] t_raw;
	wire [4:0] two_t;
	wire [7:0] half_per;
	wire [7:0] ctrl;

	assign ctrl     = regs[`BMFE_REG_CTRL];
	assign msg_len  = regs[`BMFE_REG_MSGLEN];
	// Counts above the maximum are clipped rather than overrun.
	assign t_raw    = (ctrl[`BMFE_CTRL_T_HI:`BMFE_CTRL_T_LO] >
		`BMFE_T_MAX) ? 4'd`BMFE_T_MAX :
		ctrl[`BMFE_CTRL_T_HI:`BMFE_CTRL_T_LO];
	assign two_t    = {t_raw, 1'b0};
	assign half_per = (regs[`BMFE_REG_RATE] == 8'h00) ?
		8'h01 : regs[`BMFE_REG_RATE];

	// ---------------------------------------------------------------
	// Generator polynomial builder
	// ---------------------------------------------------------------
	reg [7:0] gen [0:`BMFE_NPAR];
	reg [7:0] alpha;
	reg [4:0] gi;
	reg [4:0] built_2t;
	wire      g_restart;
	wire      g_step;
	genvar    gj;

	// Rebuilt whenever t changes; it settles within 21 clocks, which
	// control traffic alone takes far longer than.
	assign g_restart = (two_t != built_2t);
	assign g_step    = !g_restart && (gi < built_2t);

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			alpha    <= 8'h01;
			gi       <= 5'h00;
			built_2t <= 5'h00;
		end else if (g_restart) begin
			alpha    <= 8'h01;
			gi       <= 5'h00;
			built_2t <= two_t;
		end else if (g_step) begin
			alpha <= gmul(alpha, 8'h02);
			gi    <= gi + 5'h01;
		end
	end

	generate
		for (gj = 0; gj <= `BMFE_NPAR; gj = gj + 1) begin : g_gen
			wire [7:0] lower;
			if (gj == 0) begin : g_lo0
				assign lower = 8'h00;
			end else begin : g_lon
				assign lower = gen[gj-1];
			end
			// Each step multiplies the polynomial by (x + alpha^i).
			always @(posedge i_clk or negedge rst_n) begin
				if (!rst_n)
					gen[gj] <= (gj == 0) ? 8'h01 : 8'h00;
				else if (g_restart)
					gen[gj] <= (gj == 0) ? 8'h01 : 8'h00;
				else if (g_step)
					gen[gj] <= lower ^ gmul(gen[gj], alpha);
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Burst sampler
	// ---------------------------------------------------------------
	reg  [8:0] tick;
	reg  [2:0] bit_idx;
	reg  [7:0] in_byte;
	reg        byte_evt;
	reg  [7:0] strobes;
	reg        fec_burst;
	wire       gate_rise;
	wire       sample;

	assign gate_rise = gate_s & ~gate_p;
	assign sample    = gate_s && !gate_rise && (tick == 9'h000);

	// First strobe half a bit after the edge, then once per bit.
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick      <= 9'h000;
			bit_idx   <= 3'h0;
			in_byte   <= 8'h00;
			byte_evt  <= 1'b0;
			strobes   <= 8'h00;
			fec_burst <= 1'b0;
		end else begin
			byte_evt <= 1'b0;
			if (gate_rise) begin
				tick      <= {1'b0, half_per} - 9'h001;
				bit_idx   <= 3'h0;
				strobes   <= 8'h00;
				fec_burst <= ctrl[`BMFE_CTRL_FEC] | fecpin_s;
			end else if (sample) begin
				tick    <= {half_per, 1'b0} - 9'h001;
				in_byte <= {in_byte[6:0], data_s};
				bit_idx <= bit_idx + 3'h1;
				if (bit_idx == 3'h7)
					byte_evt <= 1'b1;
				if (strobes != 8'hFF)
					strobes <= strobes + 8'h01;
			end else if (gate_s) begin
				tick <= tick - 9'h001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Block-code encoder and gapping
	// ---------------------------------------------------------------
	reg  [7:0] par [0:`BMFE_NPAR-1];
	reg  [8:0] slot;
	reg  [7:0] par_top;
	reg        pend;
	reg  [7:0] pend_byte;
	wire       coding;
	wire       in_msg;
	wire       enc_en;
	wire       shout;
	wire [7:0] fb;
	wire       fifo_in_ready;
	integer    pi;

	assign coding = fec_burst && (two_t != 5'h00);
	assign in_msg = (slot < {1'b0, msg_len});
	assign enc_en = byte_evt && coding && in_msg;
	assign shout  = byte_evt && coding && !in_msg;
	assign fb     = in_byte ^ par_top;

	// The highest live parity stage depends on t.
	always @* begin
		par_top = 8'h00;
		for (pi = 0; pi < `BMFE_NPAR; pi = pi + 1)
			if (pi == two_t - 5'h01)
				par_top = par[pi];
	end

	generate
		for (gj = 0; gj < `BMFE_NPAR; gj = gj + 1) begin : g_par
			wire [7:0] prev;
			if (gj == 0) begin : g_p0
				assign prev = 8'h00;
			end else begin : g_pn
				assign prev = par[gj-1];
			end
			always @(posedge i_clk or negedge rst_n) begin
				if (!rst_n)
					par[gj] <= 8'h00;
				else if (gate_rise)
					par[gj] <= 8'h00;
				else if (enc_en)
					par[gj] <= prev ^ gmul(fb, gen[gj]);
				else if (shout)
					par[gj] <= prev;
			end
		end
	endgenerate

	// Slot counter walks each codeword of K plus 2t bytes.
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot      <= 9'h000;
			pend      <= 1'b0;
			pend_byte <= 8'h00;
			o_overrun <= 1'b0;
		end else begin
			if (gate_rise) begin
				slot      <= 9'h000;
				o_overrun <= 1'b0;
			end else if (byte_evt && coding) begin
				if (slot == {1'b0, msg_len} + {4'h0, two_t} - 9'h001)
					slot <= 9'h000;
				else
					slot <= slot + 9'h001;
			end
			// A serial source cannot wait, so a full path is flagged.
			if (byte_evt) begin
				pend      <= 1'b1;
				pend_byte <= shout ? par_top : in_byte;
				if (pend && !fifo_in_ready)
					o_overrun <= 1'b1;
			end else if (pend && fifo_in_ready) begin
				pend <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Output buffer and fixed latency release
	// ---------------------------------------------------------------
	reg        released;
	wire       fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire       fifo_out_ready;

	assign fifo_out_ready = released & (~o_byte_valid | i_byte_ready);

	bmfe_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n),
		.i_in_valid  (pend),
		.i_in_data   (pend_byte),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (fifo_out_ready)
	);

	// Output opens once six symbols of bits have been taken.
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			released          <= 1'b0;
			o_byte_valid      <= 1'b0;
			o_byte            <= 8'h00;
			o_sda_out         <= 1'b0;
			o_path_order_swap <= 1'b0;
			o_fec_active      <= 1'b0;
		end else begin
			if (gate_rise)
				released <= 1'b0;
			else if (strobes >= `BMFE_LAT_SYMBOLS * `BMFE_SYM_BITS)
				released <= 1'b1;
			if (fifo_out_ready) begin
				o_byte_valid <= fifo_out_valid;
				o_byte       <= fifo_out_data;
			end
			o_sda_out         <= 1'b0;
			o_path_order_swap <= ctrl[`BMFE_CTRL_SWAP];
			// The mode of the previous burst must not leak into the
			// first cycle of a new one.
			o_fec_active      <= coding & gate_s & ~gate_rise;
		end
	end
endmodule // bmfe_top

// >>> design/bmfe_regs.vh
`ifndef BMFE_REGS_VH
`define BMFE_REGS_VH
// ---------------------------------------------------------------
// Serial control bus register map
// ---------------------------------------------------------------
`define BMFE_REG_MSGLEN     7'h00
`define BMFE_REG_CTRL       7'h01
`define BMFE_REG_RATE       7'h02
`define BMFE_REG_SEQ_LAST   7'h48
`define BMFE_REG_LAST       7'h49
`define BMFE_REG_COUNT      74
`define BMFE_WO_A_LO        7'h06
`define BMFE_WO_A_HI        7'h11
`define BMFE_WO_B_LO        7'h1E
`define BMFE_WO_B_HI        7'h47
`define BMFE_REG_RESET      8'h00
// ---------------------------------------------------------------
// Field positions in the control byte
// ---------------------------------------------------------------
`define BMFE_CTRL_T_HI      7
`define BMFE_CTRL_T_LO      4
`define BMFE_CTRL_SWAP      3
`define BMFE_CTRL_FEC       2
// ---------------------------------------------------------------
// Device-select byte layout
// ---------------------------------------------------------------
`define BMFE_DEV_FIXED      6'h01
`define BMFE_DEV_SEL_BIT    1
`define BMFE_DEV_RW_BIT     0
// ---------------------------------------------------------------
// Code and timing constants
// ---------------------------------------------------------------
`define BMFE_GF_POLY        8'h1D
`define BMFE_T_MAX          10
`define BMFE_NPAR           20
`define BMFE_LAT_SYMBOLS    6
`define BMFE_SYM_BITS       2
`endif

// >>> design/bmfe_fifo.v
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module bmfe_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             i_clk,
	input  wire             i_rst_n,
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output wire             o_in_ready,
	output wire             o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      fill;
	wire            push;
	wire            pop;

	// Full and empty come straight from the fill count.
	assign o_in_ready  = (fill != DEPTH[AW:0]);
	assign o_out_valid = (fill != {(AW+1){1'b0}});
	assign o_out_data  = mem[rd_ptr];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Storage is written only on an accepted push.
	always @(posedge i_clk) begin
		if (push)
			mem[wr_ptr] <= i_in_data;
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr + 1'b1;
			if (push & ~pop)
				fill <= fill + 1'b1;
			else if (pop & ~push)
				fill <= fill - 1'b1;
		end
	end
endmodule // bmfe_fifo

// >>> tb/bmfe_top_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checks for the modulator front end
// ---------------------------------------------------------------
module bmfe_top_sva (
	input wire       i_clk,
	input wire       i_arst_n,
	input wire       i_scl,
	input wire       i_sda,
	input wire       o_sda_out,
	input wire       o_sda_oe,
	input wire       i_burst_frame_gate,
	input wire       i_byte_ready,
	input wire       o_byte_valid,
	input wire [7:0] o_byte,
	input wire       o_fec_active,
	input wire       o_overrun,
	input wire       o_path_order_swap
);
	reg [7:0] since_rise;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	// Age of the current burst; it saturates so that old bursts stay old.
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			since_rise <= 8'hFF;
		else if ($rose(i_burst_frame_gate))
			since_rise <= 8'h00;
		else if (since_rise != 8'hFF)
			since_rise <= since_rise + 8'h01;
	end

	// Even at the fastest rate, twelve samples need 24 clocks at least.
	a_sda_out_low: assert property (o_sda_out == 1'b0)
		else $error("sda data output not low");
	a_drive_scl_low: assert property ($rose(o_sda_oe) |-> !$past(i_scl))
		else $error("sda pulled low while clock high");
	a_release_stop: assert property ($rose(i_sda) && i_scl && $past(i_scl)
		|=> !o_sda_oe [*8])
		else $error("sda driven right after stop");
	a_latency_min: assert property ($rose(o_byte_valid) |-> since_rise >= 8'h18)
		else $error("output byte before twelve bit periods");
	a_fec_in_gate: assert property ($rose(o_fec_active)
		|-> $past(i_burst_frame_gate, 2))
		else $error("encoding active without a burst");
	a_swap_acked: assert property ($changed(o_path_order_swap)
		|-> ##[0:6] o_sda_oe)
		else $error("order bit changed without an acked write");
	a_byte_hold: assert property (o_byte_valid && !i_byte_ready
		|=> o_byte_valid && $stable(o_byte))
		else $error("output byte dropped while stalled");
	a_overrun_clear: assert property ($rose(i_burst_frame_gate)
		|-> ##[1:6] !o_overrun)
		else $error("overrun not cleared by new burst");

	c_ack: cover property ($rose(o_sda_oe));
	c_fec: cover property ($rose(o_fec_active));
	c_overrun: cover property ($rose(o_overrun));
endmodule // bmfe_top_sva

bind bmfe_top bmfe_top_sva i_bmfe_top_sva (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.i_burst_frame_gate(i_burst_frame_gate), .i_byte_ready(i_byte_ready),
	.o_byte_valid(o_byte_valid), .o_byte(o_byte),
	.o_fec_active(o_fec_active), .o_overrun(o_overrun),
	.o_path_order_swap(o_path_order_swap)
);

// >>> tb/bmfe_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus master and burst source facing the front end
// ---------------------------------------------------------------
module bmfe_host_model (
	input  wire  i_clk,
	input  wire  i_sda,
	output logic o_scl,
	output logic o_sda_low,
	output logic o_gate,
	output logic o_data
);
	int half_bit = 4;

	// Bus idles released with its clock parked high; the gate idles low.
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		o_gate = 1'b0;
		o_data = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Data moves mid low phase and is read late in the high phase, since
	// the device answers only a few clocks after each falling edge.
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		o_sda_low <= ~b;
		tick(2);
		o_scl <= 1'b1;
		tick(3);
		#1 r = i_sda;
		@(posedge i_clk);
		o_scl <= 1'b0;
	endtask

	// Also serves as repeated start, entered with the clock low.
	task automatic bus_start();
		tick(2);
		o_sda_low <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		o_sda_low <= 1'b1;
		tick(2);
		o_scl <= 1'b0;
	endtask

	task automatic bus_stop();
		tick(2);
		o_sda_low <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(2);
		o_sda_low <= 1'b0;
		tick(4);
	endtask

	// Eight bits MSB first, then the acknowledge slot.
	task automatic xfer(input logic [7:0] d, input logic mack,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(mack, ack);
	endtask

	// The released data line toggles so a stale level is never mistaken.
	task automatic gate_set(input logic g);
		@(posedge i_clk);
		o_gate <= g;
		if (!g)
			o_data <= ~o_data;
	endtask

	task automatic send_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			o_data <= d[i];
			tick(2 * half_bit);
		end
	endtask
endmodule // bmfe_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench for the modulator front end
// ---------------------------------------------------------------
module tb_top;
	logic        i_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        i_fec_enable = 1'b0;
	logic        i_byte_ready = 1'b1;
	logic        i_addr_sel = 1'b0;
	wire         scl, sda_low, gate, sdata, sda_out, sda_oe, sda;
	wire         swap, fec_act, overrun, byte_valid;
	wire  [7:0]  byte_out;
	logic [7:0]  wbuf [0:79];
	logic [7:0]  shadow [0:73];
	logic [7:0]  exp [0:17];
	logic [7:0]  got [$];
	logic [7:0]  d, fb, p1, p0;
	int          mismatches = 0;
	int          comparisons = 0;

	always #10 i_clk = ~i_clk;

	// Open-drain line with pull-up: low while either party pulls it.
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

	// Every accepted output byte is queued for comparison.
	always @(posedge i_clk)
		if (byte_valid && i_byte_ready)
			got.push_back(byte_out);

	bmfe_top i_bmfe_top (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_sel(i_addr_sel),
		.i_burst_frame_gate(gate), .i_serial_data(sdata),
		.i_fec_enable(i_fec_enable), .o_path_order_swap(swap),
		.o_fec_active(fec_act), .o_overrun(overrun),
		.o_byte_valid(byte_valid), .o_byte(byte_out),
		.i_byte_ready(i_byte_ready)
	);

	bmfe_host_model i_bmfe_host_model (
		.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
		.o_gate(gate), .o_data(sdata)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [7:0] xt(input logic [7:0] x);
		return {x[6:0], 1'b0} ^ (x[7] ? 8'h1D : 8'h00);
	endfunction

	// Write n bytes of wbuf from register a; the acks are predicted.
	task automatic wr(input logic [7:0] a, input int n);
		logic [7:0] q;
		logic ack, ok;
		ok = (a <= 8'h49);
		i_bmfe_host_model.bus_start();
		i_bmfe_host_model.xfer({6'h01, i_addr_sel, 1'b0}, 1'b1, q, ack);
		check(ack, 1'b0);
		i_bmfe_host_model.xfer(a, 1'b1, q, ack);
		check(ack, !ok);
		for (int i = 0; ok && i < n; i++) begin
			ok = (i == 0) || (a + i <= 8'h48);
			i_bmfe_host_model.xfer(wbuf[i], 1'b1, q, ack);
			check(ack, !ok);
			if (ok)
				shadow[a + i] = wbuf[i];
		end
		i_bmfe_host_model.bus_stop();
	endtask

	// Read n registers from a; the master refuses the last byte.
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] q, e;
		logic ack;
		int p;
		i_bmfe_host_model.bus_start();
		i_bmfe_host_model.xfer({6'h01, i_addr_sel, 1'b0}, 1'b1, q, ack);
		i_bmfe_host_model.xfer(a, 1'b1, q, ack);
		i_bmfe_host_model.bus_start();
		i_bmfe_host_model.xfer({6'h01, i_addr_sel, 1'b1}, 1'b1, q, ack);
		check(ack, 1'b0);
		for (int i = 0; i < n; i++) begin
			p = a + i;
			e = shadow[p];
			if ((p >= 8'h06 && p <= 8'h11) || (p >= 8'h1E && p <= 8'h47)
				|| (i > 0 && p > 8'h48))
				e = 8'h00;
			i_bmfe_host_model.xfer(8'hFF, i == n - 1, q, ack);
			check(q, e);
		end
		i_bmfe_host_model.bus_stop();
	endtask

	// Cut a hang short; the whole run needs well under a millisecond.
	initial begin
		#1_000_000;
		mismatches++;
		final_report();
	end

	// Main sequence: bus checks first, then bursts in every coding mode.
	initial begin
		for (int i = 0; i < 74; i++)
			shadow[i] = 8'h00;
		repeat (12) @(posedge i_clk);
		i_arst_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		check(sda_oe, 1'b0);
		rd(8'h00, 6);
		for (int j = 0; j < 4; j++) begin
			i_bmfe_host_model.bus_start();
			i_bmfe_host_model.xfer(8'(32'h060C0084 >> (8 * j)), 1'b1, d, fb[0]);
			check(fb[0], 1'b1);
			i_bmfe_host_model.bus_stop();
		end
		// Strap high from here on: the low-strap select is now refused.
		i_addr_sel <= 1'b1;
		i_bmfe_host_model.bus_start();
		i_bmfe_host_model.xfer(8'h04, 1'b1, d, fb[0]);
		check(fb[0], 1'b1);
		i_bmfe_host_model.bus_stop();
		for (int i = 0; i < 74; i++)
			wbuf[i] = 8'(8'h30 + i);
		wr(8'h00, 74);
		rd(8'h00, 74);
		wbuf[0] = 8'hC3;
		wr(8'h49, 1);
		rd(8'h49, 1);
		wr(8'h4A, 1);
		wbuf[0] = 8'h18;
		wr(8'h01, 1);
		check(swap, 1'b1);
		wbuf[0] = 8'h10;
		wbuf[1] = 8'h14;
		wbuf[2] = 8'h04;
		wr(8'h00, 3);
		check(swap, 1'b0);
		rd(8'h00, 3);
		for (int m = 0; m < 4; m++) begin
			wbuf[0] = 8'(32'h04101014 >> (8 * m));
			wr(8'h01, 1);
			i_fec_enable <= m[0];
			got.delete();
			p1 = 8'h00;
			p0 = 8'h00;
			i_bmfe_host_model.gate_set(1'b1);
			for (int i = 0; i < 18; i++) begin
				d = (i < 16) ? 8'(8'h03 * i + m) : 8'hA5;
				exp[i] = d;
				if (i < 16) begin
					fb = d ^ p1;
					p1 = p0 ^ xt(fb) ^ fb;
					p0 = xt(fb);
				end else if (m < 2)
					exp[i] = (i == 16) ? p1 : p0;
				i_bmfe_host_model.send_byte(d);
				if (i == 1)
					check(fec_act, m < 2);
			end
			i_bmfe_host_model.gate_set(1'b0);
			for (int w = 0; w < 400 && got.size() < 18; w++)
				@(posedge i_clk);
			check(8'(got.size()), 8'h12);
			for (int i = 0; i < 18 && i < got.size(); i++)
				check(got[i], exp[i]);
		end
		i_byte_ready <= 1'b0;
		i_bmfe_host_model.gate_set(1'b1);
		for (int i = 0; i < 8; i++)
			i_bmfe_host_model.send_byte(8'h5A);
		i_bmfe_host_model.gate_set(1'b0);
		check(overrun, 1'b1);
		i_byte_ready <= 1'b1;
		repeat (20) @(posedge i_clk);
		check(byte_valid, 1'b0);
		i_bmfe_host_model.gate_set(1'b1);
		repeat (8) @(posedge i_clk);
		check(overrun, 1'b0);
		i_bmfe_host_model.gate_set(1'b0);
		// Three resets in mid-run clear every register, 48h included.
		repeat (3) begin
			i_arst_n <= 1'b0;
			repeat (2) @(posedge i_clk);
			i_arst_n <= 1'b1;
			repeat (6) @(posedge i_clk);
		end
		for (int i = 0; i < 74; i++)
			shadow[i] = 8'h00;
		rd(8'h48, 1);
		wbuf[0] = 8'h5C;
		wr(8'h48, 1);
		rd(8'h48, 1);
		final_report();
	end
endmodule // tb_top
